// ==== src/oarp_ctrl.sv ====
// output align, reset and power-down control of a clock generator
`timescale 1ns/1ns
`default_nettype none
module oarp_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_align_n,
  input wire logic i_sleep_pin_n,
  input wire logic i_cal_busy,
  input wire logic i_cp_event,
  input wire logic i_wr_en,
  input wire logic [9:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [9:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic [5:0] o_out,
  output logic [5:0] o_out_off,
  output logic [5:0] o_out_protect,
  output logic o_loop_pd,
  output logic o_osc_pd,
  output logic o_inbuf_pd,
  output logic o_dist_bias_off,
  output logic o_align_busy
);
  // ==========================================================
  // pin synchronisers
  logic align_s1_q, align_s2_q, sleep_s1_q, sleep_s2_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      align_s1_q <= 1'b1;
      align_s2_q <= 1'b1;
      sleep_s1_q <= 1'b1;
      sleep_s2_q <= 1'b1;
    end else begin
      align_s1_q <= i_align_n;
      align_s2_q <= align_s1_q;
      sleep_s1_q <= i_sleep_pin_n;
      sleep_s2_q <= sleep_s1_q;
    end
  end
  logic sleep;
  assign sleep = ~sleep_s2_q;

  // ==========================================================
  // shadow and active registers
  logic [7:0] port_cfg_q, loop_shd_q, loop_act_q, ad_shd_q, ad_act_q;
  logic [7:0] out_shd_q [oarp_pkg::NUM_OUT];
  logic [7:0] out_act_q [oarp_pkg::NUM_OUT];
  logic [7:0] ratio_shd_q [oarp_pkg::NUM_CH];
  logic [7:0] ratio_act_q [oarp_pkg::NUM_CH];
  logic [7:0] dcfg_shd_q [oarp_pkg::NUM_CH];
  logic [7:0] dcfg_act_q [oarp_pkg::NUM_CH];
  logic upd_q, soft_rst, regs_init;
  assign soft_rst = port_cfg_q[oarp_pkg::BIT_SRST_A] & port_cfg_q[oarp_pkg::BIT_SRST_B];
  assign regs_init = !i_rst_n || soft_rst;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      port_cfg_q <= oarp_pkg::RST_PORT_CFG;
    end else if (i_wr_en && i_wr_addr == oarp_pkg::ADDR_PORT_CFG) begin
      port_cfg_q <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (regs_init) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= i_wr_en && i_wr_addr == oarp_pkg::ADDR_UPDATE
        && i_wr_data[oarp_pkg::BIT_UPDATE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (regs_init) begin
      loop_shd_q <= oarp_pkg::RST_LOOP_PWR;
      ad_shd_q <= oarp_pkg::RST_ALIGN_DIST;
      loop_act_q <= oarp_pkg::RST_LOOP_PWR;
      ad_act_q <= oarp_pkg::RST_ALIGN_DIST;
    end else begin
      if (i_wr_en && i_wr_addr == oarp_pkg::ADDR_LOOP_PWR) begin
        loop_shd_q <= i_wr_data;
      end
      if (i_wr_en && i_wr_addr == oarp_pkg::ADDR_ALIGN_DIST) begin
        ad_shd_q <= i_wr_data;
      end
      if (upd_q) begin
        loop_act_q <= loop_shd_q;
        ad_act_q <= ad_shd_q;
      end
    end
  end

  genvar go_i;
  generate
    for (go_i = 0; go_i < oarp_pkg::NUM_OUT; go_i++) begin : g_outreg
      always_ff @(posedge i_clk) begin
        if (regs_init) begin
          out_shd_q[go_i] <= oarp_pkg::RST_OUT_CFG;
          out_act_q[go_i] <= oarp_pkg::RST_OUT_CFG;
        end else begin
          if (i_wr_en && i_wr_addr == oarp_pkg::ADDR_OUT_BASE + 10'(go_i)) begin
            out_shd_q[go_i] <= i_wr_data;
          end
          if (upd_q) begin
            out_act_q[go_i] <= out_shd_q[go_i];
          end
        end
      end
    end
    for (go_i = 0; go_i < oarp_pkg::NUM_CH; go_i++) begin : g_divreg
      localparam logic [9:0] RA = oarp_pkg::ADDR_DIV_BASE + 10'(oarp_pkg::DIV_STRIDE * go_i);
      always_ff @(posedge i_clk) begin
        if (regs_init) begin
          ratio_shd_q[go_i] <= oarp_pkg::RST_DIV_RATIO;
          dcfg_shd_q[go_i] <= oarp_pkg::RST_DIV_CFG;
          ratio_act_q[go_i] <= oarp_pkg::RST_DIV_RATIO;
          dcfg_act_q[go_i] <= oarp_pkg::RST_DIV_CFG;
        end else begin
          if (i_wr_en && i_wr_addr == RA) begin
            ratio_shd_q[go_i] <= i_wr_data;
          end
          if (i_wr_en && i_wr_addr == RA + 10'h001) begin
            dcfg_shd_q[go_i] <= i_wr_data;
          end
          if (upd_q) begin
            ratio_act_q[go_i] <= ratio_shd_q[go_i];
            dcfg_act_q[go_i] <= dcfg_shd_q[go_i];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // readback of the buffered registers
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    case (i_rd_addr)
      oarp_pkg::ADDR_PORT_CFG: rd_d = port_cfg_q;
      oarp_pkg::ADDR_LOOP_PWR: rd_d = loop_shd_q;
      oarp_pkg::ADDR_ALIGN_DIST: rd_d = ad_shd_q;
      oarp_pkg::ADDR_UPDATE: rd_d = {7'h00, upd_q};
      default: begin
        for (int k = 0; k < oarp_pkg::NUM_OUT; k++) begin
          if (i_rd_addr == oarp_pkg::ADDR_OUT_BASE + 10'(k)) begin
            rd_d = out_shd_q[k];
          end
        end
        for (int k = 0; k < oarp_pkg::NUM_CH; k++) begin
          if (i_rd_addr == oarp_pkg::ADDR_DIV_BASE + 10'(oarp_pkg::DIV_STRIDE * k)) begin
            rd_d = ratio_shd_q[k];
          end
          if (i_rd_addr == oarp_pkg::ADDR_DIV_BASE + 10'(oarp_pkg::DIV_STRIDE * k + 1)) begin
            rd_d = dcfg_shd_q[k];
          end
        end
      end
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= rd_d;
    end
  end

  // ==========================================================
  // align request and release timing
  logic [2:0] init_q;
  logic [4:0] lat_q;
  logic req, req_q, go, align_busy;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      init_q <= oarp_pkg::INIT_ALIGN_CYC;
    end else if (init_q != 3'h0) begin
      init_q <= init_q - 3'h1;
    end
  end
  assign req = !align_s2_q
    || ad_act_q[oarp_pkg::BIT_SOFT_ALIGN] || ad_act_q[oarp_pkg::BIT_DIST_PD]
    || soft_rst
    || init_q != 3'h0
    || sleep
    || i_cal_busy;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req_q <= 1'b1;
      lat_q <= 5'h00;
    end else begin
      req_q <= req;
      if (req) begin
        lat_q <= 5'h00;
      end else if (req_q) begin
        lat_q <= oarp_pkg::ALIGN_LAT_CYC;
      end else if (lat_q != 5'h00) begin
        lat_q <= lat_q - 5'h01;
      end
    end
  end
  assign go = lat_q == 5'h01;
  assign align_busy = req || req_q || lat_q != 5'h00;
  assign o_align_busy = align_busy;

  // ==========================================================
  // channel dividers, one per output pair
  logic [oarp_pkg::NUM_CH-1:0] ch_lvl, ch_run, ch_wait, ch_excl;
  genvar gc;
  generate
    for (gc = 0; gc < oarp_pkg::NUM_CH; gc++) begin : g_ch
      logic run_q, wait_q, lvl_q, sh, excl;
      logic [5:0] dly_q, dc;
      logic [3:0] cnt_q, lo_cyc, hi_cyc;
      logic [4:0] phi;
      assign lo_cyc = ratio_act_q[gc][7:4];
      assign hi_cyc = ratio_act_q[gc][3:0];
      assign sh = dcfg_act_q[gc][oarp_pkg::BIT_START_LVL];
      assign excl = dcfg_act_q[gc][oarp_pkg::BIT_EXCLUDE];
      assign phi = {sh, dcfg_act_q[gc][3:0]};
      assign dc = sh ? 6'(phi - oarp_pkg::DLY_WRAP) + 6'(lo_cyc) + 6'h01
        : 6'(phi);
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          run_q <= 1'b0;
          wait_q <= 1'b0;
          lvl_q <= 1'b0;
          dly_q <= 6'h00;
          cnt_q <= 4'h0;
        end else if (sleep) begin
          run_q <= 1'b0;
          wait_q <= 1'b0;
          lvl_q <= 1'b0;
        end else if (align_busy && !excl && !go) begin
          run_q <= 1'b0;
          wait_q <= 1'b0;
          lvl_q <= sh;
        end else if (go && !excl) begin
          wait_q <= 1'b1;
          run_q <= 1'b0;
          dly_q <= dc;
        end else if (wait_q) begin
          if (dly_q == 6'h00) begin
            wait_q <= 1'b0;
            run_q <= 1'b1;
            lvl_q <= 1'b1;
            cnt_q <= hi_cyc;
          end else begin
            dly_q <= dly_q - 6'h01;
          end
        end else if (!run_q) begin
          run_q <= excl;
          lvl_q <= 1'b1;
          cnt_q <= hi_cyc;
        end else if (cnt_q == 4'h0) begin
          lvl_q <= !lvl_q;
          cnt_q <= lvl_q ? lo_cyc : hi_cyc;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
      assign ch_lvl[gc] = lvl_q;
      assign ch_run[gc] = run_q;
      assign ch_wait[gc] = wait_q;
      assign ch_excl[gc] = excl;
    end
  endgenerate

  // ==========================================================
  // output stages and power state
  logic dist_pd, sync_pd_q;
  logic [1:0] loop_mode;
  assign dist_pd = ad_act_q[oarp_pkg::BIT_DIST_PD];
  assign loop_mode = loop_act_q[1:0];
  genvar gk;
  generate
    for (gk = 0; gk < oarp_pkg::NUM_OUT; gk++) begin : g_out
      logic [1:0] pd_mode;
      logic off, prot;
      assign pd_mode = out_act_q[gk][1:0];
      assign off = pd_mode[1] || sleep || dist_pd;
      assign prot = sleep || (off && pd_mode != oarp_pkg::OUT_PD_TOTAL);
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          o_out[gk] <= 1'b0;
          o_out_off[gk] <= 1'b0;
          o_out_protect[gk] <= 1'b0;
        end else begin
          o_out[gk] <= off ? 1'b0
            : ch_lvl[gk/2] ^ out_act_q[gk][oarp_pkg::BIT_OUT_INV];
          o_out_off[gk] <= off;
          o_out_protect[gk] <= prot;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_pd_q <= 1'b0;
    end else if (loop_mode != oarp_pkg::LOOP_PD_SYNC) begin
      sync_pd_q <= 1'b0;
    end else if (i_cp_event) begin
      sync_pd_q <= 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_loop_pd <= 1'b0;
      o_osc_pd <= 1'b0;
      o_inbuf_pd <= 1'b0;
      o_dist_bias_off <= 1'b0;
    end else begin
      o_loop_pd <= sleep || loop_mode == oarp_pkg::LOOP_PD_ASYNC || sync_pd_q;
      o_osc_pd <= sleep;
      o_inbuf_pd <= sleep;
      o_dist_bias_off <= dist_pd || sleep;
    end
  end

  // ==========================================================
  // checks
  sequence s_quiet_release;
    (req_q && !req) ##1 (!req)[*7] ##1 (!req)[*6];
  endsequence
  property p_release_lat;
    @(posedge i_clk) disable iff (!i_rst_n) s_quiet_release |=> go;
  endproperty
  a_release_lat: assert property (p_release_lat) else $error("release latency wrong");
  property p_pin_align;
    @(posedge i_clk) disable iff (!i_rst_n) (!i_align_n)[*3] |-> align_busy;
  endproperty
  a_pin_align: assert property (p_pin_align) else $error("align pin ignored");
  property p_update_clear;
    @(posedge i_clk) disable iff (!i_rst_n || soft_rst)
      (i_wr_en && i_wr_addr == oarp_pkg::ADDR_UPDATE && i_wr_data[0]) |=> upd_q ##1 !upd_q;
  endproperty
  a_update_clear: assert property (p_update_clear) else $error("update bit stuck");
  property p_align_on_update;
    @(posedge i_clk) disable iff (!i_rst_n || soft_rst)
      $changed(ad_act_q[oarp_pkg::BIT_SOFT_ALIGN]) |-> $past(upd_q);
  endproperty
  a_align_on_update: assert property (p_align_on_update) else $error("align bit w/o update");
  property p_excl_runs;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ch_excl[0] && ch_run[0] && align_busy && !sleep) |=> ch_run[0];
  endproperty
  a_excl_runs: assert property (p_excl_runs) else $error("excluded channel stopped");
  property p_held_static;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!ch_excl[1] && req && !sleep) |=> (!ch_run[1] && !ch_wait[1]);
  endproperty
  a_held_static: assert property (p_held_static) else $error("channel not held");
  property p_same_release;
    @(posedge i_clk) disable iff (!i_rst_n)
      (go && !sleep && ch_excl == 3'h0) |=> (ch_wait == 3'h7);
  endproperty
  a_same_release: assert property (p_same_release) else $error("release not common");
  property p_sleep_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      sleep |=> (o_out_off == 6'h3F && o_out_protect == 6'h3F && o_loop_pd && o_osc_pd);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep state wrong");
  property p_sync_pd;
    @(posedge i_clk) disable iff (!i_rst_n)
      (loop_mode == oarp_pkg::LOOP_PD_SYNC && !sync_pd_q && !i_cp_event && !sleep)
      |=> !o_loop_pd;
  endproperty
  a_sync_pd: assert property (p_sync_pd) else $error("loop down before charge pump");
  property p_soft_rst;
    @(posedge i_clk) disable iff (!i_rst_n)
      soft_rst |-> req ##1 (ad_act_q == 8'h00 && align_busy);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset incomplete");
endmodule
`default_nettype wire

// ==== src/oarp_pkg.sv ====
// constants for the output align, reset and power-down control block
package oarp_pkg;
  // ==========================================================
  // register offsets
  localparam logic [9:0] ADDR_PORT_CFG = 10'h000;
  localparam logic [9:0] ADDR_LOOP_PWR = 10'h010;
  localparam logic [9:0] ADDR_OUT_BASE = 10'h0F0;
  localparam logic [9:0] ADDR_DIV_BASE = 10'h190;
  localparam logic [9:0] ADDR_ALIGN_DIST = 10'h230;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  // ==========================================================
  // field positions
  localparam int BIT_SRST_A = 2;
  localparam int BIT_SRST_B = 5;
  localparam int BIT_SOFT_ALIGN = 0;
  localparam int BIT_DIST_PD = 1;
  localparam int BIT_UPDATE = 0;
  localparam int BIT_START_LVL = 4;
  localparam int BIT_EXCLUDE = 5;
  localparam int BIT_OUT_INV = 4;
  // ==========================================================
  // sizes
  localparam int NUM_CH = 3;
  localparam int NUM_OUT = 6;
  localparam int DIV_STRIDE = 3;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_LOOP_PWR = 8'h00;
  localparam logic [7:0] RST_OUT_CFG = 8'h00;
  localparam logic [7:0] RST_DIV_RATIO = 8'h00;
  localparam logic [7:0] RST_DIV_CFG = 8'h00;
  localparam logic [7:0] RST_ALIGN_DIST = 8'h00;
  // ==========================================================
  // encodings
  localparam logic [1:0] OUT_PD_SAFE = 2'h2;
  localparam logic [1:0] OUT_PD_TOTAL = 2'h3;
  localparam logic [1:0] LOOP_PD_ASYNC = 2'h1;
  localparam logic [1:0] LOOP_PD_SYNC = 2'h3;
  localparam logic [4:0] DLY_WRAP = 5'h10;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [4:0] ALIGN_LAT_CYC = 5'h0E;
  localparam logic [2:0] INIT_ALIGN_CYC = 3'h4;
endpackage

// ==== tb/oarp_host_model.sv ====
// system controller model driving register port and control pins
`timescale 1ns/1ns
`default_nettype none
module oarp_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_en,
  output logic [9:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic [9:0] o_rd_addr,
  output logic o_align_n,
  output logic o_sleep_pin_n,
  output logic o_cal_busy,
  output logic o_cp_event
);
  initial begin
    o_wr_en = 1'b0;
    o_wr_addr = 10'h3FF;
    o_wr_data = 8'hFF;
    o_rd_addr = 10'h000;
    o_align_n = 1'b1;
    o_sleep_pin_n = 1'b1;
    o_cal_busy = 1'b0;
    o_cp_event = 1'b0;
  end
  // calibration running level
  task automatic cal(input logic lvl);
    @(negedge i_clk);
    o_cal_busy = lvl;
  endtask
  // one-cycle charge-pump event
  task automatic cp_pulse();
    @(negedge i_clk);
    o_cp_event = 1'b1;
    @(negedge i_clk);
    o_cp_event = 1'b0;
  endtask
  // one byte into the shadow buffer, bus scrambled after
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
  endtask
  // copy shadow to active after every soft align change
  task automatic update();
    wr(oarp_pkg::ADDR_UPDATE, 8'h01);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_rd_addr = a;
    repeat (2) @(negedge i_clk);
    d = i_rd_data;
  endtask
  // both mirrored bits set when on, otherwise written back to the reset value
  task automatic soft_reset(input logic on);
    wr(oarp_pkg::ADDR_PORT_CFG, on ? 8'h3C : oarp_pkg::RST_PORT_CFG);
  endtask
  // low pulse on the align pin
  task automatic pulse_align(input int len);
    @(negedge i_clk);
    o_align_n = 1'b0;
    repeat (len) @(negedge i_clk);
    o_align_n = 1'b1;
  endtask
  task automatic hold_align(input logic lvl);
    @(negedge i_clk);
    o_align_n = lvl;
  endtask
  // wake needs no calibration, alignment follows the pin
  task automatic sleep(input logic lvl);
    @(negedge i_clk);
    o_sleep_pin_n = lvl;
  endtask
endmodule
`default_nettype wire

// ==== tb/output_align_reset_powerdown_ctrl_tb.sv ====
// self-checking bench for the align, reset and power-down control
`timescale 1ns/1ns
`default_nettype none
module output_align_reset_powerdown_ctrl_tb;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } oarp_row_t;
  logic clk, rst_n, cal_busy, cp_event, wr_en, align_n, sleep_n;
  logic [9:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, v;
  logic [5:0] out, out_off, out_prot;
  logic loop_pd, osc_pd, inbuf_pd, bias_off, busy;
  int err_total = 0;
  int samples_checked = 0;
  int n, tog;
  oarp_row_t rows [5];
  oarp_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_align_n(align_n),
    .i_sleep_pin_n(sleep_n), .i_cal_busy(cal_busy), .i_cp_event(cp_event),
    .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_out(out), .o_out_off(out_off),
    .o_out_protect(out_prot), .o_loop_pd(loop_pd), .o_osc_pd(osc_pd),
    .o_inbuf_pd(inbuf_pd), .o_dist_bias_off(bias_off), .o_align_busy(busy));
  oarp_host_model host (.i_clk(clk), .i_rd_data(rd_data), .o_wr_en(wr_en),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr),
    .o_align_n(align_n), .o_sleep_pin_n(sleep_n), .o_cal_busy(cal_busy),
    .o_cp_event(cp_event));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded wait for the end of an alignment
  task automatic wait_idle(input int lim);
    n = 0;
    while (busy !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        err_total++;
        $display("BAD t=%0t alignment never ended", $time);
        give_verdict();
      end
    end
  endtask
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  initial begin
    rst_n = 1'b0;
    rows[0] = '{10'h010, 8'h02, 8'h02};
    rows[1] = '{10'h0F5, 8'h10, 8'h10};
    rows[2] = '{10'h197, 8'h25, 8'h25};
    rows[3] = '{10'h196, 8'hA5, 8'hA5};
    rows[4] = '{10'h3FF, 8'hAA, 8'h00};
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    wait_idle(40);
    host.rd(oarp_pkg::ADDR_PORT_CFG, v);
    chk(v, oarp_pkg::RST_PORT_CFG);
    host.rd(oarp_pkg::ADDR_ALIGN_DIST, v);
    chk(v, oarp_pkg::RST_ALIGN_DIST);
    for (int i = 0; i < 5; i++) begin
      host.wr(rows[i].addr, rows[i].data);
      host.rd(rows[i].addr, v);
      chk(v, rows[i].exp);
    end
    // soft align needs an update on set and on clear
    host.wr(oarp_pkg::ADDR_ALIGN_DIST, 8'h01);
    settle();
    chk({7'h00, busy}, 8'h00);
    host.update();
    settle();
    chk({7'h00, busy}, 8'h01);
    host.rd(oarp_pkg::ADDR_UPDATE, v);
    chk(v, 8'h00);
    host.wr(oarp_pkg::ADDR_ALIGN_DIST, 8'h00);
    repeat (20) @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    host.update();
    wait_idle(40);
    // pin release to end of alignment
    host.pulse_align(4);
    n = 0;
    while (busy !== 1'b0 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, (n >= 15 && n <= 18)}, 8'h01);
    // channel 0 excluded, channel 1 included with start level high
    host.wr(oarp_pkg::ADDR_DIV_BASE, 8'h11);
    host.wr(oarp_pkg::ADDR_DIV_BASE + 10'h001, 8'h20);
    host.wr(oarp_pkg::ADDR_DIV_BASE + 10'h003, 8'h11);
    host.wr(oarp_pkg::ADDR_DIV_BASE + 10'h004, 8'h10);
    host.wr(oarp_pkg::ADDR_OUT_BASE + 10'h001, 8'h10);
    host.update();
    wait_idle(40);
    host.hold_align(1'b0);
    repeat (6) @(negedge clk);
    tog = 0;
    for (int i = 0; i < 8; i++) begin
      v[0] = out[0];
      @(negedge clk);
      if (out[0] !== v[0]) tog++;
      chk({6'h00, out[3:2]}, 8'h03);
      chk({7'h00, out[1]}, {7'h00, ~out[0]});
    end
    chk({7'h00, (tog > 2)}, 8'h01);
    host.hold_align(1'b1);
    wait_idle(40);
    // output power modes and distribution power-down
    host.wr(oarp_pkg::ADDR_OUT_BASE + 10'h004, 8'h02);
    host.wr(oarp_pkg::ADDR_OUT_BASE + 10'h005, 8'h03);
    host.update();
    settle();
    chk({2'h0, out_off}, 8'h30);
    chk({6'h00, out_prot[5:4]}, 8'h01);
    chk({6'h00, out[5:4]}, 8'h00);
    host.wr(oarp_pkg::ADDR_ALIGN_DIST, 8'h02);
    host.update();
    settle();
    chk({6'h00, bias_off, busy}, 8'h03);
    chk({2'h0, out_off}, 8'h3F);
    chk({6'h00, out_prot[5:4]}, 8'h01);
    host.wr(oarp_pkg::ADDR_ALIGN_DIST, 8'h00);
    host.wr(oarp_pkg::ADDR_OUT_BASE + 10'h004, 8'h00);
    host.wr(oarp_pkg::ADDR_OUT_BASE + 10'h005, 8'h00);
    host.update();
    wait_idle(40);
    chk({7'h00, bias_off}, 8'h00);
    // sleep pin, writes while asleep kept
    host.sleep(1'b0);
    settle();
    chk({4'h0, loop_pd, osc_pd, inbuf_pd, busy}, 8'h0F);
    chk({2'h0, out_off}, 8'h3F);
    chk({2'h0, out_prot}, 8'h3F);
    host.wr(oarp_pkg::ADDR_LOOP_PWR, {6'h00, oarp_pkg::LOOP_PD_ASYNC});
    host.update();
    host.rd(oarp_pkg::ADDR_LOOP_PWR, v);
    chk(v, 8'h01);
    host.sleep(1'b1);
    wait_idle(40);
    chk({5'h00, loop_pd, osc_pd, inbuf_pd}, 8'h04);
    // loop power modes
    host.wr(oarp_pkg::ADDR_LOOP_PWR, 8'h00);
    host.update();
    settle();
    chk({7'h00, loop_pd}, 8'h00);
    host.wr(oarp_pkg::ADDR_LOOP_PWR, {6'h00, oarp_pkg::LOOP_PD_ASYNC});
    settle();
    chk({7'h00, loop_pd}, 8'h00);
    host.update();
    settle();
    chk({7'h00, loop_pd}, 8'h01);
    host.wr(oarp_pkg::ADDR_LOOP_PWR, 8'h00);
    host.update();
    host.wr(oarp_pkg::ADDR_LOOP_PWR, {6'h00, oarp_pkg::LOOP_PD_SYNC});
    host.update();
    repeat (6) @(negedge clk);
    chk({7'h00, loop_pd}, 8'h00);
    host.cp_pulse();
    settle();
    chk({7'h00, loop_pd}, 8'h01);
    // calibration holds the request
    host.cal(1'b1);
    repeat (25) @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    host.cal(1'b0);
    wait_idle(40);
    // soft reset
    host.soft_reset(1'b1);
    settle();
    chk({7'h00, busy}, 8'h01);
    host.rd(oarp_pkg::ADDR_LOOP_PWR, v);
    chk(v, oarp_pkg::RST_LOOP_PWR);
    host.soft_reset(1'b0);
    wait_idle(40);
    host.rd(oarp_pkg::ADDR_PORT_CFG, v);
    chk(v, oarp_pkg::RST_PORT_CFG);
    chk({7'h00, loop_pd}, 8'h00);
    // chip reset in mid-run
    host.wr(oarp_pkg::ADDR_LOOP_PWR, {6'h00, oarp_pkg::LOOP_PD_ASYNC});
    host.update();
    settle();
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk({6'h00, loop_pd, busy}, 8'h01);
    rst_n = 1'b1;
    host.rd(oarp_pkg::ADDR_LOOP_PWR, v);
    chk(v, oarp_pkg::RST_LOOP_PWR);
    chk({7'h00, busy}, 8'h01);
    wait_idle(40);
    give_verdict();
  end
endmodule
`default_nettype wire
